// File: hw/hbr_map.svh
`ifndef HBR_MAP_SVH
`define HBR_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define HBR_ADDR_W          12
`define HBR_OFF_STAT0       12'h000
`define HBR_OFF_STAT2       12'h004
`define HBR_OFF_MASK0       12'h008
`define HBR_OFF_MASK2       12'h00c
`define HBR_OFF_DCMD        12'h010
`define HBR_OFF_EVT_STAT    12'h014
`define HBR_OFF_EVT_CLR     12'h018
`define HBR_OFF_EVT_EN      12'h01c
`define HBR_OFF_ARB_STATE   12'h020

// ****************************************
// widths and field positions
// ****************************************
`define HBR_IRQ_W           8
`define HBR_EVT_W           3
`define HBR_DCMD_W          2
`define HBR_DCMD_RDY_EN     0
`define HBR_DCMD_REQ_OD     1
`define HBR_EVT_GRANT       0
`define HBR_EVT_PREEMPT     1
`define HBR_EVT_RELEASE     2

// ****************************************
// reset values
// ****************************************
`define HBR_IMR_RST         8'hff
`define HBR_DCMD_RST        2'h0
`define HBR_EVT_EN_RST      3'h0

`endif

// File: hw/hbr_pkg.sv
package hbr_pkg;

    // ****************************************
    // arbitration states
    // ****************************************
    typedef enum logic [4:0] {
        ARB_IDLE     = 5'h01,
        ARB_REQ      = 5'h02,
        ARB_WAIT_ACK = 5'h04,
        ARB_OWN      = 5'h08,
        ARB_LEAVE    = 5'h10
    } hbr_arb_state_t;

    typedef logic [31:0] hbr_word_t;

endpackage : hbr_pkg

// File: hw/hbr_slave_ready.sv
`timescale 1ns/1ps

module hbr_slave_ready (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic host_cs_n,
    input  wire logic host_data_strobe_n,
    input  wire logic host_rd_n,
    input  wire logic host_wr_n,
    input  wire logic bus_style_select,
    output logic      ready_o,
    output logic      ready_oe
);

    // ****************************************
    // slave access detection
    // ****************************************
    // style 1 uses the data strobe, style 0 the rd/wr strobes
    logic access;
    assign access = !host_cs_n &&
                    (bus_style_select ? !host_data_strobe_n : (!host_rd_n || !host_wr_n));

    // ****************************************
    // ready drive
    // ****************************************
    // active level is low for style 1 acknowledge, high for style 0 ready
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ready_oe <= 1'b0;
            ready_o  <= 1'b1;
        end else begin
            ready_oe <= access;
            ready_o  <= !bus_style_select;
        end
    end

    AST_READY_HOLDS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        access |=> ready_oe)
        else $error("ready dropped while the slave access is still open");

    AST_READY_RELEASED: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !access |=> !ready_oe)
        else $error("ready driven with no slave access");

endmodule : hbr_slave_ready

// File: hw/hbr_host_bus_ctrl.sv
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "hbr_map.svh"

// Behaviour
// - interrupt pin active while any unmasked status bit is one.
// - reading a status register clears the bits that the read returned.
// - interrupt pin inactive whenever all status bits are clear.
// - a mask bit of zero unmasks its source, one masks it.
// - ready driven active during a host slave register access.
// - ready stays active until strobe or chip select goes inactive.
// - in master cycles ready input stretches the cycle only if enabled.
// - ready pin floats when no slave access is being answered.
// - reset low forces every register and state machine to reset state.
// - during reset every pin driver is disabled.
// - bus request driven low to ask the arbiter for mastership.
// - bus request released once granted and grant acknowledge is driven.
// - open-drain request pulled low by arbiter while owning forces release.
// - grant acknowledge held low for the whole bus occupation.
// - after grant, wait for grant acknowledge line high, then drive it low.
module hbr_host_bus_ctrl (
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`HBR_ADDR_W-1:0]  paddr,
    input  wire hbr_pkg::hbr_word_t      pwdata,
    output hbr_pkg::hbr_word_t           prdata,
    output logic                         pready,
    output logic                         pslverr,
    // interrupt sources and outputs
    input  wire logic [`HBR_IRQ_W-1:0]   irq_src0_i,
    input  wire logic [`HBR_IRQ_W-1:0]   irq_src2_i,
    output logic                         int_n_o,
    output logic                         int_n_oe,
    output logic                         irq_o,
    // host slave handshake
    input  wire logic                    host_cs_n,
    input  wire logic                    host_data_strobe_n,
    input  wire logic                    host_rd_n,
    input  wire logic                    host_wr_n,
    input  wire logic                    bus_style_select,
    input  wire logic                    ready_i,
    output logic                         ready_o,
    output logic                         ready_oe,
    // dma side
    input  wire logic                    dma_req_i,
    input  wire logic                    dma_cycle_i,
    input  wire logic                    dma_done_i,
    output logic                         dma_wait_o,
    output logic                         bus_owned_o,
    // arbitration
    input  wire logic                    bus_request_n_i,
    output logic                         bus_request_n_o,
    output logic                         bus_request_n_oe,
    input  wire logic                    bus_grant_n_i,
    input  wire logic                    bus_grant_ack_n_i,
    output logic                         bus_grant_ack_n_o,
    output logic                         bus_grant_ack_n_oe
);
    import hbr_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic [`HBR_IRQ_W-1:0]  irq_status_reg_0_q;
    logic [`HBR_IRQ_W-1:0]  irq_status_reg_2_q;
    logic [`HBR_IRQ_W-1:0]  irq_mask_reg_0_q;
    logic [`HBR_IRQ_W-1:0]  irq_mask_reg_2_q;
    logic [`HBR_DCMD_W-1:0] dma_command_reg_q;
    logic [`HBR_EVT_W-1:0]  evt_status_q;
    logic [`HBR_EVT_W-1:0]  evt_enable_q;
    logic [`HBR_EVT_W-1:0]  evt_set;
    hbr_arb_state_t         arb_q;
    hbr_arb_state_t         arb_d;
    hbr_word_t              prdata_d;
    logic                   pslverr_d;
    logic                   apb_done;
    logic                   wr_done;
    logic                   rd_done;
    logic                   preempt;
    logic                   req_od;
    logic                   rdy_active_lvl;

    function automatic logic hit(input logic [`HBR_ADDR_W-1:0] a,
                                 input logic [`HBR_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    // ****************************************
    // apb slave
    // ****************************************
    // one wait state: read data is registered so the bus outputs come from flops
    assign apb_done = psel && penable && pready;
    assign wr_done  = apb_done && pwrite;
    assign rd_done  = apb_done && !pwrite;

    always_comb begin
        prdata_d  = '0;
        pslverr_d = 1'b0;
        unique case (1'b1)
            hit(paddr, `HBR_OFF_STAT0):     prdata_d[`HBR_IRQ_W-1:0] = irq_status_reg_0_q;
            hit(paddr, `HBR_OFF_STAT2):     prdata_d[`HBR_IRQ_W-1:0] = irq_status_reg_2_q;
            hit(paddr, `HBR_OFF_MASK0):     prdata_d[`HBR_IRQ_W-1:0] = irq_mask_reg_0_q;
            hit(paddr, `HBR_OFF_MASK2):     prdata_d[`HBR_IRQ_W-1:0] = irq_mask_reg_2_q;
            hit(paddr, `HBR_OFF_DCMD):      prdata_d[`HBR_DCMD_W-1:0] = dma_command_reg_q;
            hit(paddr, `HBR_OFF_EVT_STAT):  prdata_d[`HBR_EVT_W-1:0] = evt_status_q;
            hit(paddr, `HBR_OFF_EVT_CLR):   prdata_d = '0;
            hit(paddr, `HBR_OFF_EVT_EN):    prdata_d[`HBR_EVT_W-1:0] = evt_enable_q;
            hit(paddr, `HBR_OFF_ARB_STATE): prdata_d[4:0] = arb_q;
            default:                        pslverr_d = 1'b1;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            prdata  <= (psel && penable && !pready && !pwrite) ? prdata_d : '0;
            pslverr <= psel && penable && !pready && pslverr_d;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_reg_0_q  <= `HBR_IMR_RST;
            irq_mask_reg_2_q  <= `HBR_IMR_RST;
            dma_command_reg_q <= `HBR_DCMD_RST;
            evt_enable_q      <= `HBR_EVT_EN_RST;
        end else if (wr_done) begin
            if (hit(paddr, `HBR_OFF_MASK0))
                irq_mask_reg_0_q <= pwdata[`HBR_IRQ_W-1:0];
            if (hit(paddr, `HBR_OFF_MASK2))
                irq_mask_reg_2_q <= pwdata[`HBR_IRQ_W-1:0];
            if (hit(paddr, `HBR_OFF_DCMD))
                dma_command_reg_q <= pwdata[`HBR_DCMD_W-1:0];
            if (hit(paddr, `HBR_OFF_EVT_EN))
                evt_enable_q <= pwdata[`HBR_EVT_W-1:0];
        end
    end

    // ****************************************
    // interrupt status, clear on read
    // ****************************************
    // only the bits returned by the read are cleared, so a source firing between
    // the data capture and the completing edge is not lost; a new set also wins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_reg_0_q <= '0;
            irq_status_reg_2_q <= '0;
        end else begin
            if (rd_done && hit(paddr, `HBR_OFF_STAT0))
                irq_status_reg_0_q <= (irq_status_reg_0_q & ~prdata[`HBR_IRQ_W-1:0])
                                      | irq_src0_i;
            else
                irq_status_reg_0_q <= irq_status_reg_0_q | irq_src0_i;
            if (rd_done && hit(paddr, `HBR_OFF_STAT2))
                irq_status_reg_2_q <= (irq_status_reg_2_q & ~prdata[`HBR_IRQ_W-1:0])
                                      | irq_src2_i;
            else
                irq_status_reg_2_q <= irq_status_reg_2_q | irq_src2_i;
        end
    end

    // open drain: the pin is only ever pulled low, released otherwise
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            int_n_o  <= 1'b1;
            int_n_oe <= 1'b0;
        end else begin
            int_n_o  <= 1'b0;
            int_n_oe <= |(irq_status_reg_0_q & ~irq_mask_reg_0_q)
                      || |(irq_status_reg_2_q & ~irq_mask_reg_2_q);
        end
    end

    // ****************************************
    // block event interrupt
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            evt_status_q <= '0;
            irq_o        <= 1'b0;
        end else begin
            if (wr_done && hit(paddr, `HBR_OFF_EVT_CLR))
                evt_status_q <= (evt_status_q & ~pwdata[`HBR_EVT_W-1:0]) | evt_set;
            else
                evt_status_q <= evt_status_q | evt_set;
            irq_o <= |(evt_status_q & evt_enable_q);
        end
    end

    // ****************************************
    // slave ready handshake
    // ****************************************
    hbr_slave_ready u_slave_ready (
        .clk_sys            (clk_sys),
        .rst_n              (rst_n),
        .host_cs_n          (host_cs_n),
        .host_data_strobe_n (host_data_strobe_n),
        .host_rd_n          (host_rd_n),
        .host_wr_n          (host_wr_n),
        .bus_style_select   (bus_style_select),
        .ready_o            (ready_o),
        .ready_oe           (ready_oe)
    );

    // ****************************************
    // master cycle stretch
    // ****************************************
    // ready is only sampled here, never driven, so the slave drive stays off
    assign rdy_active_lvl = !bus_style_select;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dma_wait_o <= 1'b0;
        end else begin
            dma_wait_o <= dma_cycle_i && dma_command_reg_q[`HBR_DCMD_RDY_EN]
                          && (ready_i != rdy_active_lvl);
        end
    end

    // ****************************************
    // bus arbitration
    // ****************************************
    assign req_od  = dma_command_reg_q[`HBR_DCMD_REQ_OD];
    // while owning we no longer pull the request line, so a low there is the arbiter
    assign preempt = req_od && !bus_request_n_i;

    always_comb begin
        arb_d = arb_q;
        unique case (arb_q)
            ARB_IDLE:     if (dma_req_i) arb_d = ARB_REQ;
            ARB_REQ:      if (!bus_grant_n_i) arb_d = ARB_WAIT_ACK;
            ARB_WAIT_ACK: if (bus_grant_ack_n_i) arb_d = ARB_OWN;
            ARB_OWN:      if (dma_done_i || preempt) arb_d = ARB_LEAVE;
            ARB_LEAVE:    arb_d = ARB_IDLE;
            default:      arb_d = ARB_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) arb_q <= ARB_IDLE;
        else        arb_q <= arb_d;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus_request_n_o    <= 1'b1;
            bus_request_n_oe   <= 1'b0;
            bus_grant_ack_n_o  <= 1'b1;
            bus_grant_ack_n_oe <= 1'b0;
        end else begin
            // the low request drive ends when we enter ownership; push-pull mode then keeps driving it high
            if (arb_d == ARB_REQ || arb_d == ARB_WAIT_ACK) begin
                bus_request_n_o  <= 1'b0;
                bus_request_n_oe <= 1'b1;
            end else begin
                bus_request_n_o  <= !req_od;
                bus_request_n_oe <= !req_od;
            end
            bus_grant_ack_n_o  <= 1'b0;
            bus_grant_ack_n_oe <= (arb_d == ARB_OWN);
        end
    end

    assign bus_owned_o = bus_grant_ack_n_oe;

    always_comb begin
        evt_set = '0;
        evt_set[`HBR_EVT_GRANT]   = (arb_q == ARB_WAIT_ACK) && (arb_d == ARB_OWN);
        evt_set[`HBR_EVT_PREEMPT] = (arb_q == ARB_OWN) && preempt && !dma_done_i;
        evt_set[`HBR_EVT_RELEASE] = (arb_q == ARB_LEAVE);
    end

    // ****************************************
    // checks
    // ****************************************
    AST_INT_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (|(irq_status_reg_0_q & ~irq_mask_reg_0_q)) |=> int_n_oe)
        else $error("interrupt pin not active for an unmasked status bit");

    AST_INT_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (irq_status_reg_0_q == '0 && irq_status_reg_2_q == '0) |=> !int_n_oe)
        else $error("interrupt pin active with all status bits clear");

    AST_ISR_READ_CLEARS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_done && hit(paddr, `HBR_OFF_STAT0) && irq_src0_i == '0)
        |=> ((irq_status_reg_0_q & $past(prdata[`HBR_IRQ_W-1:0])) == '0))
        else $error("status read did not clear the returned bits");

    AST_MASKED_SILENT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (irq_mask_reg_0_q == 8'hff && irq_mask_reg_2_q == 8'hff) |=> !int_n_oe)
        else $error("fully masked sources still raise the interrupt pin");

    AST_STRETCH_GATED: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !dma_command_reg_q[`HBR_DCMD_RDY_EN] |=> !dma_wait_o)
        else $error("master cycle stretched while ready input is disabled");

    AST_ACK_WAITS_LINE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (arb_q == ARB_WAIT_ACK && !bus_grant_ack_n_i) |=> !bus_grant_ack_n_oe)
        else $error("grant acknowledge driven before the previous master left");

    AST_REQ_DROPS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(bus_grant_ack_n_oe) |-> !(bus_request_n_oe && !bus_request_n_o))
        else $error("bus request still driven after taking the bus");

    AST_REQ_ASKS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (arb_q == ARB_IDLE && dma_req_i) |=> (!bus_request_n_o && bus_request_n_oe))
        else $error("bus request not driven low for a dma request");

    AST_PREEMPT_LEAVES: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (arb_q == ARB_OWN && preempt) |=> !bus_grant_ack_n_oe ##1 (arb_q == ARB_IDLE))
        else $error("bus not given up after preemption");

    AST_DONE_RELEASES: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (arb_q == ARB_OWN && dma_done_i) |=> !bus_grant_ack_n_oe)
        else $error("grant acknowledge held after the last transfer");

    AST_OWN_HELD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (arb_q == ARB_OWN) |-> (bus_grant_ack_n_oe && !bus_grant_ack_n_o))
        else $error("grant acknowledge not held low during ownership");

    AST_INT_FOLLOWS_2: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (|(irq_status_reg_2_q & ~irq_mask_reg_2_q)) |=> int_n_oe)
        else $error("interrupt pin not active for an unmasked second status bit");

    AST_STRETCH_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (dma_cycle_i && dma_command_reg_q[`HBR_DCMD_RDY_EN] && ready_i == bus_style_select)
        |=> dma_wait_o)
        else $error("master cycle not stretched while the target holds ready off");

    AST_NO_ACK_UNGRANTED: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (arb_q == ARB_REQ && bus_grant_n_i) |=> !bus_grant_ack_n_oe)
        else $error("grant acknowledge driven without a grant");

    AST_REQ_OFF_OWNED: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (arb_q == ARB_OWN) |-> !(bus_request_n_oe && !bus_request_n_o))
        else $error("bus request driven while owning the bus");

endmodule : hbr_host_bus_ctrl

// File: tb/hbr_arb_model.sv
`timescale 1ns/1ps

// ****************************************
// external bus arbiter
// ****************************************
module hbr_arb_model (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic req_wire_n,
    input  wire logic slow,
    input  wire logic preempt,
    output logic      req_pull,
    output logic      bus_grant_n
);
    logic [1:0] wait_q;

    // grant withdrawn as soon as the request line is released
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wait_q      <= 2'h0;
            bus_grant_n <= 1'b1;
        end else if (req_wire_n || req_pull) begin
            wait_q      <= 2'h0;
            bus_grant_n <= 1'b1;
        end else if (!slow || wait_q == 2'h3) begin
            bus_grant_n <= 1'b0;
        end else begin
            wait_q <= wait_q + 2'h1;
        end
    end

    // only pulls the shared request line low, never drives it high
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            req_pull <= 1'b0;
        end else begin
            req_pull <= preempt;
        end
    end
endmodule : hbr_arb_model

// File: tb/hbr_host_bus_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "hbr_map.svh"

module hbr_host_bus_ctrl_tb_top;
    import hbr_pkg::*;
    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic        int_n_o, int_n_oe, irq_o, cs_n, dstb_n, rd_n, wr_n, style, ready_i;
    logic        ready_o, ready_oe, dma_req, dma_cycle, dma_done, dma_wait, owned;
    logic        req_o, req_oe, grant_n, ack_o, ack_oe, other_busy, preempt, pull, slow;
    logic        req_wire, ack_wire;
    logic [11:0] paddr;
    logic [7:0]  src0, src2;
    hbr_word_t   pwdata, prdata, rd;
    int          errors, checked, n;

    // ****************************************
    // wires with pull-ups
    // ****************************************
    assign req_wire = !((req_oe && !req_o) || pull);
    assign ack_wire = !(ack_oe || other_busy);

    hbr_host_bus_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_src0_i(src0), .irq_src2_i(src2), .int_n_o(int_n_o),
        .int_n_oe(int_n_oe), .irq_o(irq_o), .host_cs_n(cs_n), .host_data_strobe_n(dstb_n),
        .host_rd_n(rd_n), .host_wr_n(wr_n), .bus_style_select(style), .ready_i(ready_i),
        .ready_o(ready_o), .ready_oe(ready_oe), .dma_req_i(dma_req), .dma_cycle_i(dma_cycle),
        .dma_done_i(dma_done), .dma_wait_o(dma_wait), .bus_owned_o(owned),
        .bus_request_n_i(req_wire), .bus_request_n_o(req_o), .bus_request_n_oe(req_oe),
        .bus_grant_n_i(grant_n), .bus_grant_ack_n_i(ack_wire), .bus_grant_ack_n_o(ack_o),
        .bus_grant_ack_n_oe(ack_oe));

    hbr_arb_model u_arb (.clk_sys(clk_sys), .rst_n(rst_n), .req_wire_n(req_wire),
        .slow(slow), .preempt(preempt), .req_pull(pull), .bus_grant_n(grant_n));

    // ****************************************
    // helpers
    // ****************************************
    task automatic stop_test;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // request stands until the rising edge that samples pready high; data taken there
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) chk(0, 1, "apb answer");
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "read data");
        chk(err, e, "read error");
    endtask : rdchk

    task automatic pulse(input int i);
        @(posedge clk_sys);
        if (i == 0) src0 <= 8'h08; else src2 <= 8'h08;
        @(posedge clk_sys);
        src0 <= 8'h00; src2 <= 8'h00;
        repeat (2) @(negedge clk_sys);
    endtask : pulse

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // limit well above the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        $display("mismatch at %0t: watchdog", $time);
        stop_test();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, src0, src2} = '0;
        {cs_n, dstb_n, rd_n, wr_n, style, ready_i} = 6'h3f;
        {dma_req, dma_cycle, dma_done, other_busy, preempt, slow} = '0;
        errors = 0;
        checked = 0;
        repeat (8) @(posedge clk_sys);
        chk({int_n_oe, ready_oe, req_oe, ack_oe, pready}, 0, "pins float");
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdchk(`HBR_OFF_MASK0, 32'h0000_00ff, 1'b0);
        rdchk(`HBR_OFF_ARB_STATE, 32'h1, 1'b0);
        rdchk(`HBR_OFF_DCMD, 32'h0, 1'b0);
        rdchk(12'h0fc, 32'h0, 1'b1);
        for (int i = 0; i < 2; i++) begin
            pulse(i);
            chk(int_n_oe, 0, "masked source");
            rdchk(i ? `HBR_OFF_STAT2 : `HBR_OFF_STAT0, 32'h08, 1'b0);
            rdchk(i ? `HBR_OFF_STAT2 : `HBR_OFF_STAT0, 32'h00, 1'b0);
            apb(1'b1, i ? `HBR_OFF_MASK2 : `HBR_OFF_MASK0, 32'hf7);
            pulse(i);
            chk({int_n_oe, int_n_o}, 2'h2, "irq active");
            rdchk(i ? `HBR_OFF_STAT2 : `HBR_OFF_STAT0, 32'h08, 1'b0);
            repeat (2) @(negedge clk_sys);
            chk(int_n_oe, 0, "irq inactive");
        end
        // style 1 ends by lifting the data strobe, style 0 by lifting the chip select
        for (int s = 1; s >= 0; s--) begin
            @(posedge clk_sys);
            style <= s[0];
            cs_n <= 1'b0;
            if (s == 1) dstb_n <= 1'b0; else rd_n <= 1'b0;
            repeat (2) @(negedge clk_sys);
            chk({ready_oe, ready_o}, {1'b1, ~s[0]}, "ready driven");
            repeat (3) @(negedge clk_sys);
            chk(ready_oe, 1, "ready held");
            @(posedge clk_sys);
            if (s == 1) dstb_n <= 1'b1; else cs_n <= 1'b1;
            repeat (2) @(negedge clk_sys);
            chk(ready_oe, 0, "ready floats");
            @(posedge clk_sys);
            {cs_n, dstb_n, rd_n} <= 3'h7;
        end
        apb(1'b1, `HBR_OFF_DCMD, 32'h1);
        @(posedge clk_sys);
        dma_cycle <= 1'b1; ready_i <= 1'b0;
        repeat (2) @(negedge clk_sys);
        chk(dma_wait, 1, "stretch");
        @(posedge clk_sys);
        ready_i <= 1'b1;
        repeat (2) @(negedge clk_sys);
        chk(dma_wait, 0, "target ready");
        @(posedge clk_sys);
        ready_i <= 1'b0;
        apb(1'b1, `HBR_OFF_DCMD, 32'h0);
        repeat (2) @(negedge clk_sys);
        chk(dma_wait, 0, "stretch disabled");
        @(posedge clk_sys);
        dma_cycle <= 1'b0;
        // mode 0 push-pull ends by done, mode 1 open-drain ends by preemption
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, `HBR_OFF_EVT_EN, 32'h7);
            apb(1'b1, `HBR_OFF_DCMD, m ? 32'h2 : 32'h0);
            @(posedge clk_sys);
            other_busy <= 1'b1; dma_req <= 1'b1; slow <= m[0];
            repeat (2) @(negedge clk_sys);
            chk(req_wire, 0, "request");
            repeat (8) @(negedge clk_sys);
            chk(ack_oe, 0, "wait for release");
            @(posedge clk_sys);
            other_busy <= 1'b0;
            for (n = 0; n < 20 && ack_oe !== 1'b1; n++) @(negedge clk_sys);
            chk({ack_oe, ack_o, owned, req_wire}, 4'hb, "owned, request off");
            @(posedge clk_sys);
            dma_req <= 1'b0;
            repeat (4) @(negedge clk_sys);
            chk({ack_oe, irq_o}, 2'h3, "held, granted event");
            @(posedge clk_sys);
            if (m) preempt <= 1'b1; else dma_done <= 1'b1;
            @(posedge clk_sys);
            dma_done <= 1'b0;
            repeat (3) @(negedge clk_sys);
            chk(ack_oe, 0, "bus given up");
            @(posedge clk_sys);
            preempt <= 1'b0;
            apb(1'b0, `HBR_OFF_EVT_STAT, 32'h0);
            chk(rd, m ? 32'h7 : 32'h5, "events");
            apb(1'b1, `HBR_OFF_EVT_CLR, 32'h7);
            repeat (2) @(negedge clk_sys);
            chk(irq_o, 0, "events cleared");
        end
        stop_test();
    end
endmodule : hbr_host_bus_ctrl_tb_top
